// ### src/spdp_port.sv
// Purpose: device end of the two-wire serial programming and debug port
// Assumes: programming clock runs only during frames; core clock much faster
// Notes:   link logic on PROG_CLOCK_PIN_I, core logic on CORE_CLK_I
`timescale 1ns/1ps
`default_nettype none
module spdp_port
    import spdp_pkg::*;
#(
    parameter int NUM_PAIRS = 3
) (
    // Core clock and reset
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     SYS_RST_I,
    // Programming link pins
    input  wire logic                     PROG_CLOCK_PIN_I,
    input  wire logic [NUM_PAIRS-1:0]     PROG_DATA_PIN_N_I,
    output logic      [NUM_PAIRS-1:0]     PROG_DATA_PIN_N_O,
    output logic      [NUM_PAIRS-1:0]     PROG_DATA_PIN_N_OE_O,
    input  wire logic                     MASTER_CLEAR_PIN_I,
    // Configuration
    input  wire logic [1:0]               CFG_DEBUG_PAIR_I,
    // Core side
    output logic                          PROG_MODE_O,
    output logic                          ENH_MODE_O,
    output logic                          DEBUG_MODE_O,
    output logic                          EXEC_MEM_OPEN_O,
    output logic                          XFER_VALID_O,
    output logic      [1:0]               XFER_KIND_O,
    output logic      [INSN_W-1:0]        XFER_DATA_O,
    input  wire logic [DATA_W-1:0]        READ_DATA_I
);
    // Core domain
    logic                master_clear_pin_s1_reg, master_clear_pin_s2_reg, en_reg;
    logic [1:0]          dbg_pair_reg;
    logic [2:0]          mode_s1_reg, mode_s2_reg;
    logic [2:0]          xreq_s_reg, rreq_s_reg;
    logic [DATA_W-1:0]   rd_hold_reg;
    // Link domain, except enh_used_reg on the core clock
    logic                en_l1_reg, en_l2_reg;
    logic [1:0]          pair_l1_reg, pair_l2_reg;
    logic                enh_l1_reg, enh_l2_reg;
    spdp_lstate_e        st_reg;
    spdp_mode_e          mode_reg;
    logic [CNT_W-1:0]    cnt_reg, len_reg;
    logic [KEY_W-1:0]    sh_reg;
    logic [CMD_W-1:0]    cmd_reg;
    logic                xreq_tog_reg, rreq_tog_reg, oe_reg, enh_used_reg;
    logic [1:0]          kind_reg;
    logic [INSN_W-1:0]   word_reg;
    logic [DATA_W-1:0]   out_reg;
    logic [2:0]          mode_flags;
    logic [NUM_PAIRS-1:0] pair_en;
    logic                din, link_rst, cnt_end;
    logic [KEY_W-1:0]    sh_next;

    // Core: master clear synchroniser and mode enable
    always_ff @(posedge CORE_CLK_I) begin
        master_clear_pin_s1_reg <= MASTER_CLEAR_PIN_I;
        master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            en_reg <= 1'b0;
        end else begin
            en_reg <= master_clear_pin_s2_reg;
        end
    end

    // Strap taken while reset is held, so it is settled at release
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            dbg_pair_reg <= CFG_DEBUG_PAIR_I;
        end
    end

    // Core: mode flags and request toggles from the link
    // Cleared with the enable so a link reset never reads as a toggle
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || !en_reg) begin
            mode_s1_reg <= 3'h0;
            mode_s2_reg <= 3'h0;
            xreq_s_reg  <= 3'h0;
            rreq_s_reg  <= 3'h0;
        end else begin
            mode_s1_reg <= mode_flags;
            mode_s2_reg <= mode_s1_reg;
            xreq_s_reg  <= {xreq_s_reg[1:0], xreq_tog_reg};
            rreq_s_reg  <= {rreq_s_reg[1:0], rreq_tog_reg};
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            PROG_MODE_O     <= 1'b0;
            ENH_MODE_O      <= 1'b0;
            DEBUG_MODE_O    <= 1'b0;
            EXEC_MEM_OPEN_O <= 1'b0;
        end else begin
            PROG_MODE_O     <= mode_s2_reg[0];
            ENH_MODE_O      <= mode_s2_reg[1];
            DEBUG_MODE_O    <= mode_s2_reg[2];
            // User code never reaches executive memory
            EXEC_MEM_OPEN_O <= |mode_s2_reg;
        end
    end

    // Word is held stable by the link until its next frame ends
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            XFER_VALID_O <= 1'b0;
            XFER_KIND_O  <= KIND_EXEC;
            XFER_DATA_O  <= '0;
        end else begin
            XFER_VALID_O <= xreq_s_reg[2] ^ xreq_s_reg[1];
            if (xreq_s_reg[2] ^ xreq_s_reg[1]) begin
                XFER_KIND_O <= kind_reg;
                XFER_DATA_O <= word_reg;
            end
        end
    end

    // Read answer captured on request; turnaround covers the handshake
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            rd_hold_reg <= '0;
        end else if (rreq_s_reg[2] ^ rreq_s_reg[1]) begin
            rd_hold_reg <= READ_DATA_I;
        end
    end

    // Link reset takes hold with the link clock stopped; release waits two edges
    always_ff @(posedge PROG_CLOCK_PIN_I or negedge en_reg) begin
        if (!en_reg) begin
            en_l1_reg <= 1'b0;
            en_l2_reg <= 1'b0;
        end else begin
            en_l1_reg <= 1'b1;
            en_l2_reg <= en_l1_reg;
        end
    end

    // Link: configured pair and enhanced lockout into the link clock
    always_ff @(posedge PROG_CLOCK_PIN_I) begin
        pair_l1_reg <= dbg_pair_reg;
        pair_l2_reg <= pair_l1_reg;
        enh_l1_reg  <= enh_used_reg;
        enh_l2_reg  <= enh_l1_reg;
    end

    assign link_rst   = ~en_l2_reg;
    assign mode_flags = {mode_reg == M_DEBUG, mode_reg == M_ENH, mode_reg == M_BASIC};

    // Pair gating; in debug only the configured pair is live
    generate
        for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
            assign pair_en[i] = (mode_reg != M_DEBUG) || (pair_l2_reg == 2'(i));
        end
    endgenerate

    // All enabled pairs feed one shifter; idle pairs are expected low
    assign din     = |(PROG_DATA_PIN_N_I & pair_en);
    assign sh_next = {sh_reg[KEY_W-2:0], din};
    assign cnt_end = (cnt_reg == len_reg);

    // Link step machine, classifies bits by clock count
    always_ff @(posedge PROG_CLOCK_PIN_I or posedge link_rst) begin
        if (link_rst) begin
            st_reg       <= L_KEY;
            mode_reg     <= M_NONE;
            cnt_reg      <= '0;
            len_reg      <= CNT_W'(KEY_W - 1);
            sh_reg       <= '0;
            cmd_reg      <= '0;
            xreq_tog_reg <= 1'b0;
            rreq_tog_reg <= 1'b0;
            kind_reg     <= KIND_EXEC;
            word_reg     <= '0;
            out_reg      <= '0;
            oe_reg       <= 1'b0;
        end else begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_end ? '0 : cnt_reg + 1'b1;
            unique case (st_reg)
                L_KEY: begin
                    if (cnt_end) begin
                        len_reg <= CNT_W'(CMD_W - 1);
                        st_reg  <= L_CMD;
                        if (sh_next == KEY_BASIC) begin
                            mode_reg <= M_BASIC;
                        end else if (sh_next == KEY_ENH) begin
                            mode_reg <= M_ENH;
                        end else if (sh_next == KEY_DEBUG && !enh_l2_reg) begin
                            mode_reg <= M_DEBUG;
                        end else begin
                            len_reg <= CNT_W'(KEY_W - 1);
                            st_reg  <= L_KEY;
                        end
                    end
                end
                L_CMD: begin
                    if (cnt_end) begin
                        cmd_reg <= sh_next[CMD_W-1:0];
                        if (mode_reg == M_ENH) begin
                            // Executive command set, code plus one data word
                            len_reg <= CNT_W'(DATA_W - 1);
                            kind_reg <= KIND_PE;
                            st_reg  <= L_PAY;
                        end else if (sh_next[CMD_W-1:0] == CMD_READ) begin
                            len_reg      <= CNT_W'(TURN_CYCLES - 1);
                            rreq_tog_reg <= ~rreq_tog_reg;
                            st_reg       <= L_TURN;
                        end else if (sh_next[CMD_W-1:0] == CMD_CTRL) begin
                            len_reg  <= CNT_W'(CTRL_W - 1);
                            kind_reg <= KIND_CTRL;
                            st_reg   <= L_PAY;
                        end else if (sh_next[CMD_W-1:0] == CMD_EXEC) begin
                            len_reg  <= CNT_W'(INSN_W - 1);
                            kind_reg <= KIND_EXEC;
                            st_reg   <= L_PAY;
                        end
                    end
                end
                L_PAY: begin
                    if (cnt_end) begin
                        if (kind_reg == KIND_PE) begin
                            word_reg <= {cmd_reg, 4'h0, sh_next[DATA_W-1:0]};
                        end else if (kind_reg == KIND_CTRL) begin
                            // Shifter still holds older bits above the control byte
                            word_reg <= INSN_W'(sh_next[CTRL_W-1:0]);
                        end else begin
                            word_reg <= sh_next[INSN_W-1:0];
                        end
                        xreq_tog_reg <= ~xreq_tog_reg;
                        len_reg      <= CNT_W'(CMD_W - 1);
                        st_reg       <= L_CMD;
                    end
                end
                L_TURN: begin
                    if (cnt_end) begin
                        out_reg <= rd_hold_reg;
                        oe_reg  <= 1'b1;
                        // One extra clock lets the host take the line back
                        len_reg <= CNT_W'(DATA_W);
                        st_reg  <= L_OUT;
                    end
                end
                L_OUT: begin
                    out_reg <= {out_reg[DATA_W-2:0], 1'b0};
                    // Release early so the next command bit is not masked
                    if (cnt_reg == CNT_W'(DATA_W - 1)) begin
                        oe_reg <= 1'b0;
                    end
                    if (cnt_end) begin
                        len_reg <= CNT_W'(CMD_W - 1);
                        st_reg  <= L_CMD;
                    end
                end
            endcase
        end
    end

    // Enhanced use survives sessions; only core reset clears it
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            enh_used_reg <= 1'b0;
        end else if (mode_s2_reg[1]) begin
            enh_used_reg <= 1'b1;
        end
    end

    // Pin drivers, a data flop and an enable flop per pair
    always_ff @(posedge PROG_CLOCK_PIN_I or posedge link_rst) begin
        if (link_rst) begin
            PROG_DATA_PIN_N_O    <= '0;
            PROG_DATA_PIN_N_OE_O <= '0;
        end else begin
            PROG_DATA_PIN_N_O    <= {NUM_PAIRS{out_reg[DATA_W-1]}};
            PROG_DATA_PIN_N_OE_O <= {NUM_PAIRS{oe_reg}} & pair_en;
        end
    end
endmodule
`default_nettype wire

// ### src/spdp_pkg.sv
// Purpose: constants for the serial programming and debug port
// Assumes: MSB-first serial framing on the programming clock
// Notes:   key values are arbitrary
package spdp_pkg;
    localparam int          CMD_W       = 4;
    localparam int          KEY_W       = 32;
    localparam int          INSN_W      = 24;
    localparam int          CTRL_W      = 8;
    localparam int          DATA_W      = 16;
    localparam int          TURN_CYCLES = 8;
    localparam int          CNT_W       = 6;
    // Entry keys, values arbitrary
    localparam logic [31:0] KEY_BASIC   = 32'h4B1D_0001;
    localparam logic [31:0] KEY_ENH     = 32'h4B1D_0002;
    localparam logic [31:0] KEY_DEBUG   = 32'h4B1D_0003;
    // Basic command codes
    localparam logic [3:0]  CMD_EXEC    = 4'h0;
    localparam logic [3:0]  CMD_READ    = 4'h1;
    localparam logic [3:0]  CMD_CTRL    = 4'h2;
    // Transfer kinds handed to the core
    localparam logic [1:0]  KIND_EXEC   = 2'h0;
    localparam logic [1:0]  KIND_CTRL   = 2'h1;
    localparam logic [1:0]  KIND_PE     = 2'h2;
    typedef enum logic [2:0] {L_KEY, L_CMD, L_PAY, L_TURN, L_OUT} spdp_lstate_e;
    typedef enum logic [1:0] {M_NONE, M_BASIC, M_ENH, M_DEBUG} spdp_mode_e;
endpackage

// ### verif/spdp_port_monitor.sv
// Purpose: port checker for spdp_port
// Assumes: debug pair setting changes only under reset
// Notes:   bound to every spdp_port below
`timescale 1ns/1ps
`default_nettype none
module spdp_port_monitor
    import spdp_pkg::*;
#(
    parameter int NUM_PAIRS = 3
) (
    // Clock, reset, pins
    input wire logic                 CORE_CLK_I,
    input wire logic                 SYS_RST_I,
    input wire logic                 MASTER_CLEAR_PIN_I,
    input wire logic [NUM_PAIRS-1:0] PROG_DATA_PIN_N_OE_O,
    input wire logic [1:0]           CFG_DEBUG_PAIR_I,
    // Core side
    input wire logic                 PROG_MODE_O,
    input wire logic                 ENH_MODE_O,
    input wire logic                 DEBUG_MODE_O,
    input wire logic                 EXEC_MEM_OPEN_O,
    input wire logic                 XFER_VALID_O,
    input wire logic [1:0]           XFER_KIND_O,
    input wire logic [INSN_W-1:0]    XFER_DATA_O
);
    logic [1:0] cfg_reg;
    logic       any_mode;
    assign any_mode = PROG_MODE_O | ENH_MODE_O | DEBUG_MODE_O;
    // Pair index is only taken while reset is held
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            cfg_reg <= CFG_DEBUG_PAIR_I;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_closed;
        !any_mode ##1 !any_mode;
    endsequence
    a_rst_quiet: assert property ($past(SYS_RST_I) |-> !any_mode && !XFER_VALID_O)
        else $error("busy after reset");
    a_xfer_pulse: assert property (XFER_VALID_O |=> !XFER_VALID_O)
        else $error("long transfer pulse");
    a_mem_closed: assert property (s_closed |-> !EXEC_MEM_OPEN_O)
        else $error("executive memory open");
    a_oe_mode: assert property (|PROG_DATA_PIN_N_OE_O |-> any_mode)
        else $error("pin driven outside mode");
    a_dbg_pair: assert property (DEBUG_MODE_O && |PROG_DATA_PIN_N_OE_O |->
        PROG_DATA_PIN_N_OE_O == NUM_PAIRS'(1) << cfg_reg) else $error("wrong debug pair");
    a_mode_drop: assert property ($fell(MASTER_CLEAR_PIN_I) |-> ##[1:20] !any_mode)
        else $error("mode kept");
    a_pe_kind: assert property (XFER_VALID_O |-> (XFER_KIND_O == KIND_PE) == ENH_MODE_O)
        else $error("kind against mode");
    a_ctrl_low: assert property (XFER_VALID_O && XFER_KIND_O == KIND_CTRL |->
        XFER_DATA_O[INSN_W-1:CTRL_W] == '0) else $error("control upper bits");
endmodule
bind spdp_port spdp_port_monitor #(.NUM_PAIRS(NUM_PAIRS)) i_mon (
    .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .MASTER_CLEAR_PIN_I(MASTER_CLEAR_PIN_I),
    .PROG_DATA_PIN_N_OE_O(PROG_DATA_PIN_N_OE_O), .CFG_DEBUG_PAIR_I(CFG_DEBUG_PAIR_I),
    .PROG_MODE_O(PROG_MODE_O), .ENH_MODE_O(ENH_MODE_O), .DEBUG_MODE_O(DEBUG_MODE_O),
    .EXEC_MEM_OPEN_O(EXEC_MEM_OPEN_O), .XFER_VALID_O(XFER_VALID_O),
    .XFER_KIND_O(XFER_KIND_O), .XFER_DATA_O(XFER_DATA_O));
`default_nettype wire

// ### verif/spdp_prog_model.sv
// Purpose: programmer model at the far end of the link
// Assumes: 15 ns link clock, still between frames
// Notes:   data changes only while the clock is low
`timescale 1ns/1ps
`default_nettype none
module spdp_prog_model (
    // Link pins
    output logic      pclk_o,
    output logic      master_clear_pin_o,
    output logic      drv_o,
    output logic      dat_o,
    input  wire logic dat_i
);
    initial begin
        {pclk_o, master_clear_pin_o, drv_o, dat_o} = 4'h0;
    end
    task automatic pulse();
        #7.5 pclk_o = 1'b1;
        #7.5 pclk_o = 1'b0;
    endtask
    // MSB first
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            {drv_o, dat_o} = {1'b1, v[i]};
            pulse();
        end
    endtask
    // Two dummy clocks let the link leave reset
    task automatic enter(input logic [31:0] key);
        #200 master_clear_pin_o = 1'b1;
        #60 send(32'h0, 2);
        send(key, 32);
    endtask
    task automatic leave();
        #1 master_clear_pin_o = 1'b0;
        #200;
    endtask
    // Host lets go for the turnaround
    task automatic query(output logic [15:0] v);
        drv_o = 1'b0;
        repeat (8) pulse();
        for (int i = 15; i >= 0; i--) begin
            #7.5 pclk_o = 1'b1;
            #2 v[i] = dat_i;
            #5.5 pclk_o = 1'b0;
        end
        // Release clock while the device lets go of the line
        pulse();
    endtask
endmodule
`default_nettype wire

// ### verif/tb_serial_program_debug_port.sv
// Purpose: self-checking bench for spdp_port
// Assumes: the programmer uses one pair at a time
// Notes:   debug runs before enhanced, whose lockout is sticky
`timescale 1ns/1ps
`default_nettype none
module tb_serial_program_debug_port;
    import spdp_pkg::*;
    logic              clk, rst, pclk, master_clear_pin, drv, dat, pm, em, dm, mo, xv;
    logic [1:0]        cfg, sel, xk, kq;
    logic [2:0]        din, dout, oe, oe_seen;
    logic [15:0]       rdata, rv;
    logic [INSN_W-1:0] xd, dq;
    int                miscompares, cmp_count, n_xfer;
    spdp_port i_dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .PROG_CLOCK_PIN_I(pclk), .PROG_DATA_PIN_N_I(din),
        .PROG_DATA_PIN_N_O(dout), .PROG_DATA_PIN_N_OE_O(oe), .MASTER_CLEAR_PIN_I(master_clear_pin),
        .CFG_DEBUG_PAIR_I(cfg), .PROG_MODE_O(pm), .ENH_MODE_O(em), .DEBUG_MODE_O(dm),
        .EXEC_MEM_OPEN_O(mo), .XFER_VALID_O(xv), .XFER_KIND_O(xk), .XFER_DATA_O(xd),
        .READ_DATA_I(rdata));
    spdp_prog_model i_prog (.pclk_o(pclk), .master_clear_pin_o(master_clear_pin), .drv_o(drv), .dat_o(dat),
        .dat_i(din[sel]));
    // Idle pairs low, released line shows the inverse
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            din[p] = oe[p] ? dout[p] : (p == sel) ? (drv ? dat : ~dout[p]) : 1'b0;
        end
    end
    always @(posedge clk) begin
        if (xv === 1'b1) begin
            n_xfer <= n_xfer + 1;
            kq <= xk;
            dq <= xd;
        end
        if (|oe === 1'b1) oe_seen <= oe_seen | oe;
    end
    initial begin
        {clk, cfg, sel, rdata, oe_seen} = '0;
        {miscompares, cmp_count, n_xfer} = '0;
        rst = 1'b1;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic do_reset(input logic [1:0] c);
        @(posedge clk) #1 rst = 1'b1;
        cfg = c;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
    endtask
    // Bounded wait for the core-side word
    task automatic frame(input logic [3:0] c, input logic [31:0] v, input int n);
        int n0;
        n0 = n_xfer;
        i_prog.send(c, 4);
        i_prog.send(v, n);
        for (int i = 0; i < 60 && n_xfer == n0; i++) @(posedge clk) #1;
    endtask
    task automatic t_basic(input logic [1:0] p, input logic [23:0] ins);
        sel = p;
        i_prog.enter(KEY_BASIC);
        frame(CMD_EXEC, ins, 24);
        chk(pm === 1'b1 && mo === 1'b1 && kq === KIND_EXEC && dq === ins, "execute");
        frame(CMD_CTRL, 32'hA5, 8);
        chk(kq === KIND_CTRL && dq === 24'h0000A5, "control word");
        @(posedge clk) #1 rdata = {8'h5A, 6'h00, p};
        i_prog.send(CMD_READ, 4);
        i_prog.query(rv);
        frame(CMD_EXEC, ~ins, 24);
        chk(rv === rdata && dq === ~ins, "read then execute");
        i_prog.leave();
        chk(pm === 1'b0, "exit");
    endtask
    task automatic final_report();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        do_reset(2'd0);
        chk({pm, em, dm, mo} === 4'h0, "outputs after reset");
        i_prog.send(KEY_BASIC, 32);
        frame(CMD_EXEC, 32'h123456, 24);
        chk(pm === 1'b0 && n_xfer == 0, "live without master clear");
        t_basic(2'd1, 24'h3C5A96);
        t_basic(2'd2, 24'h81F00F);
        do_reset(2'd1);
        sel = 2'd1;
        oe_seen = 3'b000;
        i_prog.enter(KEY_DEBUG);
        i_prog.send(CMD_READ, 4);
        i_prog.query(rv);
        frame(CMD_CTRL, 32'h3C, 8);
        chk(dm === 1'b1 && mo === 1'b1 && rv === rdata, "debug read");
        chk(oe_seen === 3'b010, "debug pair");
        i_prog.leave();
        i_prog.enter(KEY_ENH);
        frame(4'h5, 32'h1234, 16);
        chk(em === 1'b1 && kq === KIND_PE && dq === 24'h501234, "executive");
        i_prog.leave();
        i_prog.enter(KEY_DEBUG);
        frame(CMD_CTRL, 32'h11, 8);
        chk(dm === 1'b0, "debug after enhanced");
        final_report();
    end
    initial begin
        #50000;
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
